/* File: inc/uidmc_pkg.sv */
// Constants, encodings and register map of the identifier option and modulation configuration block.
package uidmc_pkg;

   // Command code bytes.
   localparam logic [7:0] CMD_IDENTIFIER_USAGE = 8'h40;
   localparam logic [7:0] CMD_SET_MODULATION   = 8'h43;

   // Identifier usage type bytes.
   localparam logic [7:0] TYPE_DOUBLE_STANDARD = 8'h00;
   localparam logic [7:0] TYPE_DOUBLE_SHORTCUT = 8'h40;
   localparam logic [7:0] TYPE_SINGLE_RANDOM   = 8'h20;
   localparam logic [7:0] TYPE_SINGLE_DERIVED  = 8'h60;

   // Modulation strength type bytes.
   localparam logic [7:0] TYPE_MOD_STRONG = 8'h01;
   localparam logic [7:0] TYPE_MOD_NORMAL = 8'h00;

   // Manufacturer byte of block 0 that reports the modulation strength.
   localparam logic [7:0] MFR_MOD_STRONG = 8'h20;
   localparam logic [7:0] MFR_MOD_NORMAL = 8'h00;

   // Four-bit answer codes.
   localparam logic [3:0] ANS_ACK     = 4'ha;
   localparam logic [3:0] ANS_INVALID = 4'h0;
   localparam logic [3:0] ANS_CRC_ERR = 4'h1;

   // Cascade tag that leads the first level of a double-size identifier.
   localparam logic [7:0] CASCADE_TAG_BYTE = 8'h88;

   // Activation sequence numbers as reported by the anti-collision logic.
   localparam logic [1:0] SEQ_NONE  = 2'h0;
   localparam logic [1:0] SEQ_ONE   = 2'h1;
   localparam logic [1:0] SEQ_TWO   = 2'h2;
   localparam logic [1:0] SEQ_THREE = 2'h3;

   // Identifier functionalities.
   typedef enum logic [1:0] {
      double_size_standard_mode = 2'b00,
      double_size_shortcut_mode = 2'b01,
      single_random_id_mode     = 2'b10,
      single_derived_id_mode    = 2'b11
   } uidmc_mode_e;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } uidmc_state_e;

   // Frame delay from reader frame end to card answer.
   localparam int CLK_HZ      = 20000000;
   localparam int FDT_MIN_US  = 87;
   localparam int FDT_CYC     = (FDT_MIN_US * CLK_HZ + 999999) / 1000000;
   localparam int FDT_W       = 11;

   // Register byte offsets.
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_UID_LO = 8'h04;
   localparam logic [7:0] OFF_UID_HI = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;

   // Values after reset.
   localparam logic        RST_UID_SEVEN = 1'b1;
   localparam logic [31:0] RST_UID_LO    = 32'h00000000;
   localparam logic [23:0] RST_UID_HI    = 24'h000000;
   localparam logic        RST_STRONG    = 1'b1;

   // Status register field positions.
   localparam int STS_ACTIVE_LSB  = 0;
   localparam int STS_PENDING_LSB = 2;
   localparam int STS_LOCK        = 4;
   localparam int STS_STRONG_ACT  = 5;
   localparam int STS_STRONG_PEND = 6;
   localparam int STS_ANSWER_LSB  = 8;
   localparam int STS_BUSY        = 12;

endpackage

/* File: verilog/uidmc_config.sv */
// Identifier usage and load modulation command handling with an APB register file.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module uidmc_config (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        resetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Received reader frames from the frame decoder.
   input  wire logic        frameValid,
   input  wire logic [7:0]  frameCode,
   input  wire logic [7:0]  frameType,
   input  wire logic        frameIntact,
   // Session state from the anti-collision and authentication logic.
   input  wire logic        authSector0,
   input  wire logic        authKeyA,
   input  wire logic        sessionEnd,
   input  wire logic [1:0]  seqUsed,
   input  wire logic [31:0] randomId,
   // Answer to the reader.
   output logic             answerValid,
   output logic [3:0]       answerCode,
   // Settings in force for the session.
   output logic [1:0]       activeMode,
   output logic             strongModulation,
   output logic [7:0]       mfrModByte,
   output logic [3:1]       seqAllowed,
   output logic             cascadeTwo,
   output logic [31:0]      authInput,
   output logic             block0Plain,
   output logic             atqaDoubleSize
);

   // Folds the stored identifier into a single-size identifier.
   function automatic logic [31:0] deriveId(input logic [55:0] uid);
      deriveId = uid[31:0] ^ {8'h00, uid[55:32]};
   endfunction

   // Returns the functionality chosen by a usage type byte and whether the byte is listed.
   function automatic logic [2:0] decodeUsage(input logic [7:0] typeByte);
      case (typeByte)
         uidmc_pkg::TYPE_DOUBLE_STANDARD: decodeUsage = {1'b1, uidmc_pkg::double_size_standard_mode};
         uidmc_pkg::TYPE_DOUBLE_SHORTCUT: decodeUsage = {1'b1, uidmc_pkg::double_size_shortcut_mode};
         uidmc_pkg::TYPE_SINGLE_RANDOM:   decodeUsage = {1'b1, uidmc_pkg::single_random_id_mode};
         uidmc_pkg::TYPE_SINGLE_DERIVED:  decodeUsage = {1'b1, uidmc_pkg::single_derived_id_mode};
         default:                         decodeUsage = 3'h0;
      endcase
   endfunction

   // Registers.
   logic                     uidSeven_q;
   logic [31:0]              uidLo_q;
   logic [23:0]              uidHi_q;
   uidmc_pkg::uidmc_mode_e   pendMode_q;
   uidmc_pkg::uidmc_mode_e   actMode_q;
   logic                     lock_q;
   logic                     pendStrong_q;
   logic                     actStrong_q;
   uidmc_pkg::uidmc_state_e  state_q;
   logic [uidmc_pkg::FDT_W-1:0] wait_q;
   logic [3:0]               answer_q;
   logic                     answerValid_q;
   logic [31:0]              prdata_q;
   logic                     pslverr_q;

   // Bus decode.
   wire        apbAccess  = psel & penable;
   wire        apbWrite   = apbAccess & pwrite;
   wire        hitCtrl    = (paddr == uidmc_pkg::OFF_CTRL);
   wire        hitUidLo   = (paddr == uidmc_pkg::OFF_UID_LO);
   wire        hitUidHi   = (paddr == uidmc_pkg::OFF_UID_HI);
   wire        hitStatus  = (paddr == uidmc_pkg::OFF_STATUS);
   wire        hitAny     = hitCtrl | hitUidLo | hitUidHi | hitStatus;
   wire [55:0] uidFull    = {uidHi_q, uidLo_q};

   logic [31:0] statusWord;
   always_comb begin
      statusWord = 32'h00000000;
      statusWord[uidmc_pkg::STS_ACTIVE_LSB +: 2]  = actMode_q;
      statusWord[uidmc_pkg::STS_PENDING_LSB +: 2] = pendMode_q;
      statusWord[uidmc_pkg::STS_LOCK]             = lock_q;
      statusWord[uidmc_pkg::STS_STRONG_ACT]       = actStrong_q;
      statusWord[uidmc_pkg::STS_STRONG_PEND]      = pendStrong_q;
      statusWord[uidmc_pkg::STS_ANSWER_LSB +: 4]  = answer_q;
      statusWord[uidmc_pkg::STS_BUSY]             = (state_q == uidmc_pkg::ST_WAIT);
   end

   wire [31:0] readMux = hitCtrl   ? {31'h00000000, uidSeven_q} :
                         hitUidLo  ? uidLo_q :
                         hitUidHi  ? {8'h00, uidHi_q} :
                         hitStatus ? statusWord : 32'h00000000;

   // Command decode, taken only when no answer is outstanding.
   wire        frameTaken  = frameValid & (state_q == uidmc_pkg::ST_IDLE);
   wire        isUsageCmd  = (frameCode == uidmc_pkg::CMD_IDENTIFIER_USAGE);
   wire        isModCmd    = (frameCode == uidmc_pkg::CMD_SET_MODULATION);
   wire [2:0]  usageDec    = decodeUsage(frameType);
   wire        usageListed = usageDec[2];
   wire        modListed   = (frameType == uidmc_pkg::TYPE_MOD_STRONG) | (frameType == uidmc_pkg::TYPE_MOD_NORMAL);
   // The usage command exists only for the 7-byte variant and is refused once locked.
   wire        usageOk     = isUsageCmd & frameIntact & uidSeven_q & authSector0
                             & ~lock_q & usageListed;
   wire        modOk       = isModCmd & frameIntact & authSector0 & authKeyA & modListed;
   wire        acceptUsage = frameTaken & usageOk;
   wire        acceptMod   = frameTaken & modOk;
   wire [3:0]  answerNext  = ~frameIntact        ? uidmc_pkg::ANS_CRC_ERR :
                             (usageOk | modOk)   ? uidmc_pkg::ANS_ACK : uidmc_pkg::ANS_INVALID;
   wire        fdtDone     = (wait_q == uidmc_pkg::FDT_W'(uidmc_pkg::FDT_CYC - 1));

   // APB write registers and read data.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         uidSeven_q <= uidmc_pkg::RST_UID_SEVEN;
         uidLo_q    <= uidmc_pkg::RST_UID_LO;
         uidHi_q    <= uidmc_pkg::RST_UID_HI;
         prdata_q   <= 32'h00000000;
         pslverr_q  <= 1'b0;
      end else begin
         if (apbWrite && hitCtrl) begin
            uidSeven_q <= pwdata[0];
         end
         if (apbWrite && hitUidLo) begin
            uidLo_q <= pwdata;
         end
         if (apbWrite && hitUidHi) begin
            uidHi_q <= pwdata[23:0];
         end
         if (psel && !penable) begin
            prdata_q  <= readMux;
            pslverr_q <= ~hitAny | (pwrite & hitStatus);
         end
      end
   end

   // Personalization settings: pending values change on commands, active values at session end.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pendMode_q   <= uidmc_pkg::double_size_standard_mode;
         actMode_q    <= uidmc_pkg::double_size_standard_mode;
         lock_q       <= 1'b0;
         pendStrong_q <= uidmc_pkg::RST_STRONG;
         actStrong_q  <= uidmc_pkg::RST_STRONG;
      end else begin
         if (acceptUsage) begin
            pendMode_q <= uidmc_pkg::uidmc_mode_e'(usageDec[1:0]);
            lock_q     <= 1'b1;
         end
         if (acceptMod) begin
            pendStrong_q <= (frameType == uidmc_pkg::TYPE_MOD_STRONG);
         end
         // A command in the same cycle as session end lands in the next session.
         if (sessionEnd) begin
            actMode_q   <= acceptUsage ? uidmc_pkg::uidmc_mode_e'(usageDec[1:0]) : pendMode_q;
            actStrong_q <= acceptMod ? (frameType == uidmc_pkg::TYPE_MOD_STRONG) : pendStrong_q;
         end
      end
   end

   // Answer timer: the frame delay is counted from the end of the reader frame.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q       <= uidmc_pkg::ST_IDLE;
         wait_q        <= '0;
         answer_q      <= uidmc_pkg::ANS_INVALID;
         answerValid_q <= 1'b0;
      end else begin
         answerValid_q <= 1'b0;
         case (state_q)
            uidmc_pkg::ST_IDLE: begin
               if (frameValid && (isUsageCmd || isModCmd || !frameIntact)) begin
                  state_q  <= uidmc_pkg::ST_WAIT;
                  wait_q   <= '0;
                  answer_q <= answerNext;
               end
            end
            uidmc_pkg::ST_WAIT: begin
               if (fdtDone) begin
                  state_q       <= uidmc_pkg::ST_IDLE;
                  answerValid_q <= 1'b1;
               end else begin
                  wait_q <= wait_q + 1'b1;
               end
            end
            default: begin
               state_q <= uidmc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Session-facing decode of the active settings.
   wire        modeDouble  = uidSeven_q & ((actMode_q == uidmc_pkg::double_size_standard_mode)
                             | (actMode_q == uidmc_pkg::double_size_shortcut_mode));
   wire        modeShort   = uidSeven_q & (actMode_q == uidmc_pkg::double_size_shortcut_mode);
   wire [31:0] authSeqOne  = uidFull[55:24];
   wire [31:0] authSeqTwo  = {uidFull[23:0], uidmc_pkg::CASCADE_TAG_BYTE};
   wire [31:0] authSingle  = ~uidSeven_q ? uidLo_q :
                             (actMode_q == uidmc_pkg::single_random_id_mode) ? randomId :
                             deriveId(uidFull);

   assign seqAllowed      = {~modeDouble, modeShort, modeDouble};
   assign cascadeTwo      = modeDouble;
   assign authInput       = (seqUsed == uidmc_pkg::SEQ_ONE) ? authSeqOne :
                            (seqUsed == uidmc_pkg::SEQ_TWO) ? authSeqTwo : authSingle;
   assign block0Plain     = modeShort & (seqUsed == uidmc_pkg::SEQ_TWO);
   assign atqaDoubleSize  = uidSeven_q;
   assign activeMode      = actMode_q;
   assign strongModulation = actStrong_q;
   assign mfrModByte      = actStrong_q ? uidmc_pkg::MFR_MOD_STRONG : uidmc_pkg::MFR_MOD_NORMAL;
   assign answerValid     = answerValid_q;
   assign answerCode      = answer_q;
   assign pready          = 1'b1;
   assign pslverr         = apbAccess & pslverr_q;
   assign prdata          = apbAccess ? prdata_q : 32'h00000000;

   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic [uidmc_pkg::FDT_W:0] sinceFrame_q;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sinceFrame_q <= '0;
      end else if (frameTaken) begin
         sinceFrame_q <= '0;
      end else if (sinceFrame_q != '1) begin
         sinceFrame_q <= sinceFrame_q + 1'b1;
      end
   end

   fdt_min_a: assert property (answerValid |-> sinceFrame_q >= (uidmc_pkg::FDT_CYC))
      else $error("Answer sent before the frame delay elapsed.");

   lock_refuse_a: assert property (frameTaken && isUsageCmd && lock_q |=> answer_q != uidmc_pkg::ANS_ACK)
      else $error("Usage command acknowledged while locked.");

   lock_sticky_a: assert property ($rose(lock_q) |=> lock_q [*8])
      else $error("Usage lock released.");

   usage_auth_a: assert property (frameTaken && isUsageCmd && !authSector0 |=> answer_q != uidmc_pkg::ANS_ACK
                                  && $stable(lock_q) && $stable(pendMode_q))
      else $error("Usage setting accepted without authentication.");

   mod_keya_a: assert property ($changed(pendStrong_q) |-> $past(authKeyA) && $past(authSector0))
      else $error("Modulation changed without key A authentication.");

   active_hold_a: assert property (!sessionEnd |=> $stable(actMode_q) && $stable(actStrong_q))
      else $error("Active setting changed within a session.");

   mfr_byte_a: assert property (mfrModByte == (strongModulation ? 8'h20 : 8'h00))
      else $error("Manufacturer modulation byte wrong.");

   plain_read_a: assert property (block0Plain |-> actMode_q == uidmc_pkg::double_size_shortcut_mode
                                  && seqUsed == uidmc_pkg::SEQ_TWO)
      else $error("Plain block zero read outside the shortcut sequence.");

   crc_answer_a: assert property (frameTaken && !frameIntact |=> answer_q == uidmc_pkg::ANS_CRC_ERR
                                  && state_q == uidmc_pkg::ST_WAIT)
      else $error("Damaged frame not answered with the CRC error code.");

   refuse_keep_a: assert property (frameTaken && !(usageOk || modOk) |=> $stable(pendMode_q)
                                   && $stable(pendStrong_q))
      else $error("Refused command changed a setting.");

   four_byte_a: assert property (!uidSeven_q |-> seqAllowed == 3'b100 && !cascadeTwo)
      else $error("4-byte variant allows a double-size sequence.");

endmodule

/* File: verif/uidmc_reader_model.sv */
// Reader-side model that drives command frames and session state into the block.
`timescale 1ns/1ns
module uidmc_reader_model (
   // Clock.
   input  wire logic        clk,
   // Received frames.
   output logic             frameValid,
   output logic [7:0]       frameCode,
   output logic [7:0]       frameType,
   output logic             frameIntact,
   // Session state.
   output logic             authSector0,
   output logic             authKeyA,
   output logic             sessionEnd,
   output logic [1:0]       seqUsed,
   output logic [31:0]      randomId
);
   initial begin
      frameValid = 1'b0;
      frameCode = 8'h00;
      frameType = 8'h00;
      frameIntact = 1'b1;
      authSector0 = 1'b0;
      authKeyA = 1'b0;
      sessionEnd = 1'b0;
      seqUsed = 2'h0;
      randomId = 32'h0;
   end

   task automatic session(input logic a, input logic k, input logic [1:0] s, input logic [31:0] r);
      @(posedge clk);
      authSector0 <= a;
      authKeyA <= k;
      seqUsed <= s;
      randomId <= r;
   endtask

   task automatic send(input logic [7:0] c, input logic [7:0] t, input logic ok);
      @(posedge clk);
      frameValid <= 1'b1;
      frameCode <= c;
      frameType <= t;
      frameIntact <= ok;
      @(posedge clk);
      frameValid <= 1'b0;
      // Released bytes flip so a stale command can never pass for a fresh one.
      frameCode <= ~c;
      frameType <= ~t;
      frameIntact <= ~ok;
   endtask

   task automatic unselect;
      @(posedge clk);
      sessionEnd <= 1'b1;
      authSector0 <= 1'b0;
      authKeyA <= 1'b0;
      seqUsed <= 2'h0;
      @(posedge clk);
      sessionEnd <= 1'b0;
   endtask
endmodule

/* File: verif/uidmc_config_tb.sv */
// Self-checking testbench of the identifier option and modulation block.
`timescale 1ns/1ns
module uidmc_config_tb;
   localparam logic [32:0] ALL = {33{1'b1}};
   localparam logic [32:0] ERR = {1'b1, 32'h0};
   logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic        frameValid, frameIntact, authSector0, authKeyA, sessionEnd;
   logic        answerValid, strongModulation, cascadeTwo, block0Plain, atqaDoubleSize;
   logic [1:0]  seqUsed, activeMode;
   logic [3:0]  answerCode;
   logic [3:1]  seqAllowed;
   logic [7:0]  paddr, frameCode, frameType, mfrModByte;
   logic [31:0] pwdata, prdata, randomId, authInput, rlo, rhi, rnd;
   logic [32:0] apbQ[$];
   logic [32:0] apbM[$];
   logic [3:0]  ansQ[$];
   int          cycQ[$];
   int          numErrors = 0;
   int          numChecks = 0;
   int          cyc = 0;
   logic [7:0]  types[4] = '{8'h00, 8'h20, 8'h60, 8'h40};
   logic [1:0]  modes[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   logic [3:1]  allow[4] = '{3'b001, 3'b100, 3'b100, 3'b011};

   uidmc_config i_dut (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .frameValid(frameValid),
      .frameCode(frameCode), .frameType(frameType), .frameIntact(frameIntact), .authSector0(authSector0),
      .authKeyA(authKeyA), .sessionEnd(sessionEnd), .seqUsed(seqUsed), .randomId(randomId),
      .answerValid(answerValid), .answerCode(answerCode), .activeMode(activeMode),
      .strongModulation(strongModulation), .mfrModByte(mfrModByte), .seqAllowed(seqAllowed),
      .cascadeTwo(cascadeTwo), .authInput(authInput), .block0Plain(block0Plain), .atqaDoubleSize(atqaDoubleSize)
   );

   uidmc_reader_model i_reader (
      .clk(clk), .frameValid(frameValid), .frameCode(frameCode), .frameType(frameType),
      .frameIntact(frameIntact), .authSector0(authSector0), .authKeyA(authKeyA), .sessionEnd(sessionEnd),
      .seqUsed(seqUsed), .randomId(randomId)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   task automatic endOfTest;
      $display("Checks %0d, errors %0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      numChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic timed_out;
      numErrors++;
      $display("ERROR at %0t: wait expired, got %h expected %h", $time, 1'b0, 1'b1);
      endOfTest();
   endtask

   // Called right after a clock edge, so reset is sampled low at exactly two edges.
   task automatic reset_dut;
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                      input logic [32:0] m);
      int n = 0;
      apbQ.push_back(e);
      apbM.push_back(m);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) timed_out();
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Notes the expected answer, sends the frame and waits for the answer pulse.
   task automatic frame(input logic [7:0] c, input logic [7:0] t, input logic ok, input logic [3:0] e);
      int n = 0;
      ansQ.push_back(e);
      i_reader.send(c, t, ok);
      cycQ.push_back(cyc);
      while (answerValid !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n == 2000) timed_out();
   endtask

   always @(posedge clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         check({pslverr, prdata} & apbM[0], apbQ[0]);
         void'(apbQ.pop_front());
         void'(apbM.pop_front());
      end
      if (answerValid === 1'b1) begin
         check({29'h0, answerCode}, {29'h0, ansQ[0]});
         check({32'h0, (cyc - cycQ[0]) >= uidmc_pkg::FDT_CYC}, 33'h1);
         void'(ansQ.pop_front());
         void'(cycQ.pop_front());
      end
   end

   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rnd = $urandom(18428);
      reset_dut();
      apb(1'b0, uidmc_pkg::OFF_CTRL, 32'h0, 33'h1, ALL);
      apb(1'b0, uidmc_pkg::OFF_STATUS, 32'h0, 33'h60, ALL);
      apb(1'b0, 8'h10, 32'h0, ERR, ALL);
      apb(1'b1, uidmc_pkg::OFF_STATUS, 32'h5, ERR, ERR);
      check({25'h0, mfrModByte}, 33'h20);
      check({30'h0, seqAllowed}, 33'h1);
      $display("Test registers done");
      i_reader.session(1'b0, 1'b0, 2'h1, rnd);
      frame(8'h43, 8'h00, 1'b1, 4'h0);
      i_reader.session(1'b1, 1'b0, 2'h1, rnd);
      frame(8'h43, 8'h00, 1'b1, 4'h0);
      i_reader.session(1'b1, 1'b1, 2'h1, rnd);
      frame(8'h43, 8'h02, 1'b1, 4'h0);
      frame(8'h43, 8'h00, 1'b1, 4'ha);
      check({32'h0, strongModulation}, 33'h1);
      i_reader.unselect();
      @(posedge clk);
      check({24'h0, strongModulation, mfrModByte}, 33'h0);
      i_reader.session(1'b1, 1'b1, 2'h1, rnd);
      repeat (2) frame(8'h43, 8'h01, 1'b1, 4'ha);
      i_reader.unselect();
      @(posedge clk);
      check({24'h0, strongModulation, mfrModByte}, 33'h120);
      $display("Test modulation done");
      frame(8'h40, 8'h40, 1'b1, 4'h0);
      i_reader.session(1'b1, 1'b0, 2'h1, rnd);
      frame(8'h40, 8'h10, 1'b1, 4'h0);
      frame(8'h40, 8'h40, 1'b0, 4'h1);
      apb(1'b0, uidmc_pkg::OFF_STATUS, 32'h0, 33'h160, ALL);
      for (int i = 0; i < 4; i++) begin
         reset_dut();
         i_reader.session(1'b1, 1'b0, 2'h1, rnd);
         frame(8'h40, types[i], 1'b1, 4'ha);
         apb(1'b0, uidmc_pkg::OFF_STATUS, 32'h0, {21'h0, 12'ha70 | {8'h0, modes[i], 2'b00}}, ALL);
         frame(8'h40, 8'h00, 1'b1, 4'h0);
         check({31'h0, activeMode}, 33'h0);
         i_reader.unselect();
         @(posedge clk);
         check({31'h0, activeMode}, {31'h0, modes[i]});
         check({30'h0, seqAllowed}, {30'h0, allow[i]});
         i_reader.session(1'b1, 1'b0, 2'h3, rnd);
         @(posedge clk);
         if (i == 1) check({1'b0, authInput}, {1'b0, rnd});
         // The stored identifier is still zero after reset, so its folded form is zero as well.
         if (i == 2) check({1'b0, authInput}, 33'h0);
      end
      $display("Test identifier usage done");
      rlo = $urandom();
      rhi = $urandom();
      apb(1'b1, uidmc_pkg::OFF_UID_LO, rlo, 33'h0, ERR);
      apb(1'b1, uidmc_pkg::OFF_UID_HI, rhi, 33'h0, ERR);
      apb(1'b0, uidmc_pkg::OFF_UID_HI, 32'h0, {9'h0, rhi[23:0]}, ALL);
      i_reader.session(1'b1, 1'b0, 2'h1, rnd);
      @(posedge clk);
      check({1'b0, authInput}, {1'b0, rhi[23:0], rlo[31:24]});
      check({30'h0, cascadeTwo, block0Plain, atqaDoubleSize}, 33'h5);
      i_reader.session(1'b1, 1'b0, 2'h2, rnd);
      @(posedge clk);
      check({1'b0, authInput}, {1'b0, rlo[23:0], 8'h88});
      check({32'h0, block0Plain}, 33'h1);
      apb(1'b1, uidmc_pkg::OFF_CTRL, 32'h0, 33'h0, ERR);
      i_reader.session(1'b1, 1'b0, 2'h3, rnd);
      @(posedge clk);
      check({1'b0, authInput}, {1'b0, rlo});
      check({31'h0, cascadeTwo, atqaDoubleSize}, 33'h0);
      $display("Test selection and authentication done");
      endOfTest();
   end
endmodule
